//--- dsv_device.sv
// Drive object dictionary end: statusword, mode objects and velocity objects
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (R1) Init 0000 bit6 clear; waiting 0000 bit6 set
// (R2) Bit5 set: 0001, 0011, 0111 power states
// (R3) Quick stop: 0111, bits 5,6 clear
// (R4) Fault reaction 1111; fault 1000; bit6 clear
// (R5) Only bits 0-3,5,6 encode drive state
// (R6) Bit 4 set while power section fed
// (R7) Warning and internal limit bits carry nothing
// (R8) Bit 9 mirrors internal status remote bit
// (R9) Bit 10: at reference, quick stop or halt
// (R10) Bits 8, 12-15 reserved, read zero
// (R11) Statusword read-only 16 bits; no writes
// (R12) Mode select signed 8-bit; only 2 valid
// (R13) Mode report shows active mode, same code
// (R14) Ramp enable: bit6 set, halt clear
// (R15) Master sets controlword bit 4 for ramp
// (R16) Speed reference signed 16-bit rw, reset 0
// (R17) Negative reference sets reverse direction bit
// (R18) Ramped reference read-only signed 16-bit
// (R19) Measured speed; equals ramped without feedback
// (R20) Speed limits positive only, both directions
// (R21) Limit array: count 2, min, max
// (R22) Controlword bit7 rising edge resets fault
// (R23) Unsupported mode write refused, mode kept
module dsv_device (
  input wire logic pclk,
  input wire logic presetn,
  dsv_link_if.device link,
  input wire dsv_pkg::dsv_state_t drive_state,
  input wire logic power_fed,
  input wire logic [15:0] internal_status_word_param,
  input wire logic at_reference,
  input wire logic feedback_present,
  input wire logic [15:0] ramped_speed,
  input wire logic [15:0] motor_speed_param,
  output logic [15:0] network_control_word_param,
  output logic [15:0] network_speed_ref_param,
  output logic [31:0] min_speed_param,
  output logic [31:0] max_speed_param,
  output logic [7:0] active_mode,
  output logic fault_reset
);
  // ==========================================================================
  // Stored objects
  logic [15:0] ctrl_ff;
  logic [15:0] speed_ref_ff;
  logic [31:0] min_ff;
  logic [31:0] max_ff;
  logic [7:0] mode_ff;
  logic [15:0] status_ff;
  logic [15:0] nxt_status;
  logic ack_ff;
  logic err_ff;
  logic [31:0] rdata_ff;
  logic fault_reset_ff;
  logic take;
  logic wr_ok;
  logic [31:0] rd_val;
  logic rd_ok;

  assign take = link.req && !ack_ff;

  // ==========================================================================
  // Statusword assembly
  always_comb begin
    nxt_status = 16'h0000;
    case (drive_state)
      dsv_pkg::DSV_NOT_READY: nxt_status[3:0] = 4'h0; // see (R1)
      dsv_pkg::DSV_SW_ON_DIS: begin
        nxt_status[3:0] = 4'h0;
        nxt_status[dsv_pkg::SW_SOD] = 1'b1; // see (R1)
      end
      dsv_pkg::DSV_READY: begin
        nxt_status[3:0] = 4'h1;
        nxt_status[dsv_pkg::SW_QSTOP] = 1'b1; // see (R2)
      end
      dsv_pkg::DSV_SWITCHED_ON: begin
        nxt_status[3:0] = 4'h3;
        nxt_status[dsv_pkg::SW_QSTOP] = 1'b1; // see (R2)
      end
      dsv_pkg::DSV_OP_ENABLED: begin
        nxt_status[3:0] = 4'h7;
        nxt_status[dsv_pkg::SW_QSTOP] = 1'b1; // see (R2)
      end
      dsv_pkg::DSV_QSTOP: nxt_status[3:0] = 4'h7; // see (R3)
      dsv_pkg::DSV_FAULT_REACT: nxt_status[3:0] = 4'hf; // see (R4)
      dsv_pkg::DSV_FAULT: nxt_status[3:0] = 4'h8; // see (R4)
      default: nxt_status[3:0] = 4'h0;
    endcase
    nxt_status[dsv_pkg::SW_VOLT] = power_fed; // see (R6)
    nxt_status[dsv_pkg::SW_REMOTE] = internal_status_word_param[dsv_pkg::IS_REMOTE]; // see (R8)
    nxt_status[dsv_pkg::SW_TARGET] = at_reference || (drive_state == dsv_pkg::DSV_QSTOP)
                                     || ctrl_ff[dsv_pkg::CW_HALT]; // see (R9)
    // Warning, internal limit and reserved bits stay zero, see (R7) see (R10)
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= 16'h0000;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // ==========================================================================
  // Write acceptance
  always_comb begin
    wr_ok = 1'b0;
    case (link.index)
      dsv_pkg::IDX_CTRL: wr_ok = 1'b1;
      dsv_pkg::IDX_SPEED_REF: wr_ok = 1'b1;
      dsv_pkg::IDX_MODE_SEL: wr_ok = (link.wdata[7:0] == dsv_pkg::MODE_VELOCITY); // see (R12) see (R23)
      dsv_pkg::IDX_LIMITS: wr_ok = ((link.subidx == dsv_pkg::SUB_MIN) || (link.subidx == dsv_pkg::SUB_MAX))
                                   && !link.wdata[31]; // see (R20) see (R21)
      default: wr_ok = 1'b0; // see (R11)
    endcase
  end

  // Read multiplexer
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    case (link.index)
      dsv_pkg::IDX_CTRL: rd_val = {16'h0000, ctrl_ff};
      dsv_pkg::IDX_STATUS: rd_val = {16'h0000, status_ff}; // see (R11)
      dsv_pkg::IDX_SPEED_REF: rd_val = {{16{speed_ref_ff[15]}}, speed_ref_ff}; // see (R16)
      dsv_pkg::IDX_RAMPED: rd_val = {{16{ramped_speed[15]}}, ramped_speed}; // see (R18)
      dsv_pkg::IDX_MEASURED: begin
        if (feedback_present) begin
          rd_val = {{16{motor_speed_param[15]}}, motor_speed_param}; // see (R19)
        end else begin
          rd_val = {{16{ramped_speed[15]}}, ramped_speed}; // see (R19)
        end
      end
      dsv_pkg::IDX_LIMITS: begin
        case (link.subidx)
          dsv_pkg::SUB_COUNT: rd_val = dsv_pkg::LIMIT_COUNT; // see (R21)
          dsv_pkg::SUB_MIN: rd_val = min_ff;
          dsv_pkg::SUB_MAX: rd_val = max_ff;
          default: rd_ok = 1'b0;
        endcase
      end
      dsv_pkg::IDX_MODE_SEL: rd_val = {{24{mode_ff[7]}}, mode_ff};
      dsv_pkg::IDX_MODE_REP: rd_val = {{24{mode_ff[7]}}, mode_ff}; // see (R13)
      default: rd_ok = 1'b0;
    endcase
  end

  // ==========================================================================
  // Link answer: one cycle after the request is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_ff <= 1'b0;
      err_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= take;
      if (take) begin
        err_ff <= link.wr ? !wr_ok : !rd_ok;
        rdata_ff <= link.wr ? 32'h0000_0000 : rd_val;
      end
    end
  end

  // Object stores
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= dsv_pkg::CTRL_RST;
      speed_ref_ff <= dsv_pkg::SPEED_REF_RST;
      min_ff <= dsv_pkg::MIN_SPEED_RST;
      max_ff <= dsv_pkg::MAX_SPEED_RST;
      mode_ff <= dsv_pkg::MODE_VELOCITY;
    end else if (take && link.wr && wr_ok) begin
      case (link.index)
        dsv_pkg::IDX_CTRL: ctrl_ff <= link.wdata[15:0];
        dsv_pkg::IDX_SPEED_REF: speed_ref_ff <= link.wdata[15:0]; // see (R16)
        dsv_pkg::IDX_MODE_SEL: mode_ff <= link.wdata[7:0]; // see (R23)
        dsv_pkg::IDX_LIMITS: begin
          if (link.subidx == dsv_pkg::SUB_MIN) begin
            min_ff <= link.wdata;
          end else begin
            max_ff <= link.wdata;
          end
        end
        default: ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // Fault reset on rising controlword bit 7
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_reset_ff <= 1'b0;
    end else begin
      fault_reset_ff <= take && link.wr && (link.index == dsv_pkg::IDX_CTRL)
                        && link.wdata[dsv_pkg::CW_FAULT_RST] && !ctrl_ff[dsv_pkg::CW_FAULT_RST]; // see (R22)
    end
  end

  // ==========================================================================
  // Internal control outputs
  always_comb begin
    network_control_word_param = 16'h0000;
    network_control_word_param[dsv_pkg::NC_RAMP] = ctrl_ff[dsv_pkg::CW_RAMP]
                                                   && !ctrl_ff[dsv_pkg::CW_HALT]; // see (R14)
    network_control_word_param[dsv_pkg::NC_ENABLE] = (drive_state == dsv_pkg::DSV_OP_ENABLED)
                                                     || (drive_state == dsv_pkg::DSV_QSTOP);
    network_control_word_param[dsv_pkg::NC_REVERSE] = speed_ref_ff[15]; // see (R17)
    network_control_word_param[dsv_pkg::NC_REMOTE] = ctrl_ff[dsv_pkg::CW_REMOTE_SEL];
  end

  assign network_speed_ref_param = speed_ref_ff[15] ? 16'(-speed_ref_ff) : speed_ref_ff;
  assign min_speed_param = min_ff;
  assign max_speed_param = max_ff;
  assign active_mode = mode_ff;
  assign fault_reset = fault_reset_ff;
  assign link.ack = ack_ff;
  assign link.err = err_ff;
  assign link.rdata = rdata_ff;
endmodule
`default_nettype wire

//--- dsv_link_if.sv
// Object access link between network master and drive object logic
`timescale 1ns/1ps
`default_nettype none
interface dsv_link_if;
  logic req;
  logic wr;
  logic [15:0] index;
  logic [7:0] subidx;
  logic [31:0] wdata;
  logic ack;
  logic err;
  logic [31:0] rdata;
  modport master (output req, output wr, output index, output subidx, output wdata,
                  input ack, input err, input rdata);
  modport device (input req, input wr, input index, input subidx, input wdata,
                  output ack, output err, output rdata);
endinterface
`default_nettype wire

//--- dsv_link_monitor.sv
// Checker for the object access link between the master and drive ends
`timescale 1ns/1ps
`default_nettype none
module dsv_link_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic wr,
  input wire logic [15:0] index,
  input wire logic [7:0] subidx,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic err,
  input wire logic [31:0] rdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // Handshake
  property p_taken_ack; req && !ack |=> ack; endproperty
  a_taken_ack: assert property (p_taken_ack) else $error("ack missing after request");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_req_hold;
    req && !ack |=> req && $stable(wr) && $stable(index) && $stable(subidx) && $stable(wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_req_drop; ack |=> !req; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request not dropped after ack");
  property p_wr_zero; ack && wr |-> rdata == 32'h0000_0000; endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write answer carries data");
  // ==========================================================================
  // Object contents
  property p_status_rsvd;
    ack && !wr && index == 16'h6041 |-> !err && rdata[31:12] == 20'h00000 && !rdata[8];
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("reserved status bits set");
  property p_status_state;
    ack && !wr && index == 16'h6041 |->
      (rdata[6:0] & 7'h6f) inside {7'h00, 7'h40, 7'h21, 7'h23, 7'h27, 7'h07, 7'h0f, 7'h08};
  endproperty
  a_status_state: assert property (p_status_state) else $error("illegal state code");
  property p_mode_val;
    ack && !wr && (index == 16'h6060 || index == 16'h6061) |-> !err && rdata == 32'h0000_0002;
  endproperty
  a_mode_val: assert property (p_mode_val) else $error("mode object not velocity");
  property p_lim_count;
    ack && !wr && index == 16'h6046 && subidx == 8'h00 |-> !err && rdata == 32'h0000_0002;
  endproperty
  a_lim_count: assert property (p_lim_count) else $error("limit count wrong");
  property p_lim_sub; ack && index == 16'h6046 && subidx > 8'h02 |-> err; endproperty
  a_lim_sub: assert property (p_lim_sub) else $error("bad limit sub accepted");
  property p_sext;
    ack && !wr && index inside {16'h6042, 16'h6043, 16'h6044} |-> !err && rdata[31:16] == {16{rdata[15]}};
  endproperty
  a_sext: assert property (p_sext) else $error("speed not sign extended");
  property p_ro_refuse;
    ack && wr && index inside {16'h6041, 16'h6043, 16'h6044, 16'h6061} |-> err;
  endproperty
  a_ro_refuse: assert property (p_ro_refuse) else $error("read-only write accepted");
endmodule
`default_nettype wire

//--- dsv_master.sv
// Network master end: APB-programmed object access and state decode
`timescale 1ns/1ps
`default_nettype none
module dsv_master (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  dsv_link_if.master link
);
  // ==========================================================================
  // Registers
  logic [15:0] index_ff;
  logic [7:0] subidx_ff;
  logic [31:0] wdata_ff;
  logic [31:0] rdata_ff;
  logic wr_ff;
  logic req_ff;
  logic err_ff;
  logic refused_ff;
  logic [15:0] sword_ff;
  logic [2:0] state_ff;
  logic [2:0] nxt_state;
  logic apb_wr;
  logic start;
  logic bad;

  assign apb_wr = psel && penable && pwrite;
  assign start = apb_wr && (paddr == dsv_pkg::REG_CMD) && pwdata[0] && !req_ff;

  // Local refusal of writes the device must never see
  always_comb begin
    bad = 1'b0;
    if (pwdata[1]) begin
      case (index_ff)
        dsv_pkg::IDX_STATUS: bad = 1'b1; // see (R11)
        dsv_pkg::IDX_MODE_SEL: bad = (wdata_ff[7:0] != dsv_pkg::MODE_VELOCITY); // see (R12)
        dsv_pkg::IDX_LIMITS: bad = wdata_ff[31]; // see (R20)
        default: bad = 1'b0;
      endcase
    end
  end

  // Drive state decode from masked statusword
  always_comb begin
    case (sword_ff & dsv_pkg::SW_STATE_MASK) // see (R5)
      16'h0040: nxt_state = dsv_pkg::DSV_SW_ON_DIS;
      16'h0021: nxt_state = dsv_pkg::DSV_READY;
      16'h0023: nxt_state = dsv_pkg::DSV_SWITCHED_ON;
      16'h0027: nxt_state = dsv_pkg::DSV_OP_ENABLED;
      16'h0007: nxt_state = dsv_pkg::DSV_QSTOP;
      16'h000f, 16'h002f: nxt_state = dsv_pkg::DSV_FAULT_REACT;
      16'h0008, 16'h0028: nxt_state = dsv_pkg::DSV_FAULT;
      default: nxt_state = dsv_pkg::DSV_NOT_READY;
    endcase
  end

  // ==========================================================================
  // Setup registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_ff <= 16'h0000;
      subidx_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
    end else if (apb_wr && !req_ff) begin
      if (paddr == dsv_pkg::REG_ADDR) begin
        index_ff <= pwdata[15:0];
        subidx_ff <= pwdata[23:16];
      end else if (paddr == dsv_pkg::REG_WDATA) begin
        wdata_ff <= pwdata;
      end
    end
  end

  // Transfer engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff <= 1'b0;
      wr_ff <= 1'b0;
      err_ff <= 1'b0;
      refused_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      sword_ff <= 16'h0000;
      state_ff <= 3'b000;
    end else begin
      state_ff <= nxt_state;
      if (start) begin
        refused_ff <= bad;
        err_ff <= 1'b0;
        req_ff <= !bad;
        wr_ff <= pwdata[1];
      end else if (req_ff && link.ack) begin
        req_ff <= 1'b0;
        err_ff <= link.err;
        if (!wr_ff) begin
          rdata_ff <= link.rdata;
          if (index_ff == dsv_pkg::IDX_STATUS && !link.err) begin
            sword_ff <= link.rdata[15:0];
          end
        end
      end
    end
  end

  // ==========================================================================
  // Link drive; controlword writes always carry the ramp-follow bit
  always_comb begin
    link.wdata = wdata_ff;
    if (index_ff == dsv_pkg::IDX_CTRL) begin
      link.wdata[dsv_pkg::CW_ACCEL_RAMP] = 1'b1; // see (R15)
    end
  end
  assign link.req = req_ff;
  assign link.wr = wr_ff;
  assign link.index = index_ff;
  assign link.subidx = subidx_ff;

  // APB read side
  always_comb begin
    case (paddr)
      dsv_pkg::REG_CMD: prdata = {30'h0000_0000, wr_ff, req_ff};
      dsv_pkg::REG_ADDR: prdata = {8'h00, subidx_ff, index_ff};
      dsv_pkg::REG_WDATA: prdata = wdata_ff;
      dsv_pkg::REG_RDATA: prdata = rdata_ff;
      dsv_pkg::REG_STATUS: prdata = {25'h000_0000, state_ff, 1'b0, refused_ff, err_ff, req_ff};
      dsv_pkg::REG_SWORD: prdata = {16'h0000, sword_ff};
      default: prdata = 32'h0000_0000;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = 1'b0;
endmodule
`default_nettype wire

//--- dsv_pkg.sv
// Shared constants and types for the drive status and velocity object block
package dsv_pkg;
  // ==========================================================================
  // Object indices and sub-indices
  localparam logic [15:0] IDX_CTRL = 16'h6040;
  localparam logic [15:0] IDX_STATUS = 16'h6041;
  localparam logic [15:0] IDX_SPEED_REF = 16'h6042;
  localparam logic [15:0] IDX_RAMPED = 16'h6043;
  localparam logic [15:0] IDX_MEASURED = 16'h6044;
  localparam logic [15:0] IDX_LIMITS = 16'h6046;
  localparam logic [15:0] IDX_MODE_SEL = 16'h6060;
  localparam logic [15:0] IDX_MODE_REP = 16'h6061;
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_MIN = 8'h01;
  localparam logic [7:0] SUB_MAX = 8'h02;
  localparam logic [31:0] LIMIT_COUNT = 32'h0000_0002;
  // ==========================================================================
  // Values and reset values
  localparam logic [7:0] MODE_VELOCITY = 8'h02;
  localparam logic [15:0] SPEED_REF_RST = 16'h0000;
  localparam logic [31:0] MIN_SPEED_RST = 32'h0000_0000;
  localparam logic [31:0] MAX_SPEED_RST = 32'h0000_0708;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // ==========================================================================
  // Statusword bit positions
  localparam int SW_VOLT = 4;
  localparam int SW_QSTOP = 5;
  localparam int SW_SOD = 6;
  localparam int SW_REMOTE = 9;
  localparam int SW_TARGET = 10;
  localparam logic [15:0] SW_STATE_MASK = 16'h006f;
  // Controlword bit positions
  localparam int CW_ACCEL_RAMP = 4;
  localparam int CW_RAMP = 6;
  localparam int CW_FAULT_RST = 7;
  localparam int CW_HALT = 8;
  localparam int CW_REMOTE_SEL = 11;
  // Internal network control word and internal status word bit positions
  localparam int NC_RAMP = 0;
  localparam int NC_ENABLE = 1;
  localparam int NC_REVERSE = 2;
  localparam int NC_REMOTE = 11;
  localparam int IS_REMOTE = 4;
  // ==========================================================================
  // Drive states
  typedef enum logic [2:0] {
    DSV_NOT_READY = 3'b000,
    DSV_SW_ON_DIS = 3'b001,
    DSV_READY = 3'b010,
    DSV_SWITCHED_ON = 3'b011,
    DSV_OP_ENABLED = 3'b100,
    DSV_QSTOP = 3'b101,
    DSV_FAULT_REACT = 3'b110,
    DSV_FAULT = 3'b111
  } dsv_state_t;
  // ==========================================================================
  // Master register map (APB byte offsets)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_SWORD = 8'h14;
endpackage

//--- dsv_testbench.sv
// Self-checking bench: APB into the master, link into the drive object end
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, power_fed = 1'b0, at_ref = 1'b0, fb = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, st, min_sp, max_sp, esw;
  logic pready, pslverr, fault_reset;
  logic [7:0] act_mode;
  logic [15:0] isw = 16'h0, ramped = 16'h0, motor = 16'h0, ncw, nsr, v, mag;
  logic [15:0] vals [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0000};
  logic [6:0] codes [8] = '{7'h00, 7'h40, 7'h21, 7'h23, 7'h27, 7'h07, 7'h0f, 7'h08};
  dsv_pkg::dsv_state_t dstate = dsv_pkg::DSV_NOT_READY;
  int miscompares = 0, comparisons = 0, pulses = 0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (fault_reset === 1'b1) pulses++;
  dsv_link_if dsv_link_if_i ();
  dsv_master dsv_master_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(dsv_link_if_i));
  dsv_device dsv_device_i (.pclk(pclk), .presetn(presetn), .link(dsv_link_if_i), .drive_state(dstate),
    .power_fed(power_fed), .internal_status_word_param(isw), .at_reference(at_ref), .feedback_present(fb),
    .ramped_speed(ramped), .motor_speed_param(motor), .network_control_word_param(ncw),
    .network_speed_ref_param(nsr), .min_speed_param(min_sp), .max_speed_param(max_sp),
    .active_mode(act_mode), .fault_reset(fault_reset));
  dsv_link_monitor dsv_link_monitor_i (.pclk(pclk), .presetn(presetn), .req(dsv_link_if_i.req),
    .wr(dsv_link_if_i.wr), .index(dsv_link_if_i.index), .subidx(dsv_link_if_i.subidx),
    .wdata(dsv_link_if_i.wdata), .ack(dsv_link_if_i.ack), .err(dsv_link_if_i.err), .rdata(dsv_link_if_i.rdata));
  // ==========================================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [31:0] sx(input logic [15:0] x);
    return {{16{x[15]}}, x};
  endfunction
  // ==========================================================================
  // Bus tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic obj(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
    int n;
    n = 0;
    apb(1'b1, dsv_pkg::REG_ADDR, {8'h00, sub, idx}, q);
    apb(1'b1, dsv_pkg::REG_WDATA, d, q);
    apb(1'b1, dsv_pkg::REG_CMD, {30'h0, w, 1'b1}, q);
    do begin
      apb(1'b0, dsv_pkg::REG_STATUS, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 20);
    if (n >= 20) begin
      miscompares++;
      tally_and_finish();
    end
    apb(1'b0, dsv_pkg::REG_RDATA, 32'h0, q);
  endtask
  task automatic rdchk(input string nm, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    obj(1'b0, idx, sub, 32'h0);
    chk(nm, q, exp);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'haf23));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("mode_sel", dsv_pkg::IDX_MODE_SEL, 8'h00, 32'h2);
    rdchk("mode_rep", dsv_pkg::IDX_MODE_REP, 8'h00, 32'h2);
    rdchk("speed_ref_rst", dsv_pkg::IDX_SPEED_REF, 8'h00, 32'h0);
    rdchk("lim_count", dsv_pkg::IDX_LIMITS, dsv_pkg::SUB_COUNT, dsv_pkg::LIMIT_COUNT);
    rdchk("lim_max_rst", dsv_pkg::IDX_LIMITS, dsv_pkg::SUB_MAX, dsv_pkg::MAX_SPEED_RST);
    $display("test reset_values done");
    for (int s = 0; s < 8; s++) begin
      dstate <= dsv_pkg::dsv_state_t'(s[2:0]);
      power_fed <= 1'($urandom);
      isw <= 16'($urandom);
      at_ref <= 1'($urandom);
      @(posedge pclk);
      obj(1'b0, dsv_pkg::IDX_STATUS, 8'h00, 32'h0);
      esw = {16'h0, 5'h00, at_ref || s == 5, isw[4], 2'b00, codes[s][6:5], power_fed, codes[s][3:0]};
      chk("statusword", q, esw);
      apb(1'b0, dsv_pkg::REG_STATUS, 32'h0, st);
      chk("decoded_state", st[6:4], s[2:0]);
    end
    $display("test statusword done");
    for (int c = 0; c < 4; c++) begin
      obj(1'b1, dsv_pkg::IDX_CTRL, 8'h00, {23'h0, c[1], 1'b0, c[0], 6'h00});
      chk("ramp_bit", ncw[0], c[0] && !c[1]);
      obj(1'b0, dsv_pkg::IDX_STATUS, 8'h00, 32'h0);
      chk("target_bit", q[10], at_ref || c[1] || dstate == dsv_pkg::DSV_QSTOP);
    end
    pulses = 0;
    obj(1'b1, dsv_pkg::IDX_CTRL, 8'h00, 32'h80);
    obj(1'b1, dsv_pkg::IDX_CTRL, 8'h00, 32'h80);
    chk("fault_reset", pulses, 32'h1);
    rdchk("ramp_follow", dsv_pkg::IDX_CTRL, 8'h00, 32'h90);
    $display("test controlword done");
    for (int k = 0; k < 6; k++) begin
      v = (k < 4) ? vals[k] : 16'($urandom);
      mag = v[15] ? (~v + 16'h0001) : v;
      obj(1'b1, dsv_pkg::IDX_SPEED_REF, 8'h00, {16'h0, v});
      rdchk("speed_ref", dsv_pkg::IDX_SPEED_REF, 8'h00, sx(v));
      chk("reverse_bit", ncw[2], v[15]);
      chk("speed_mag", nsr, mag);
    end
    ramped <= 16'($urandom);
    motor <= 16'($urandom);
    @(posedge pclk);
    rdchk("ramped", dsv_pkg::IDX_RAMPED, 8'h00, sx(ramped));
    rdchk("measured_nofb", dsv_pkg::IDX_MEASURED, 8'h00, sx(ramped));
    fb <= 1'b1;
    rdchk("measured_fb", dsv_pkg::IDX_MEASURED, 8'h00, sx(motor));
    $display("test speed_objects done");
    obj(1'b1, dsv_pkg::IDX_LIMITS, dsv_pkg::SUB_MIN, 32'd100);
    obj(1'b1, dsv_pkg::IDX_LIMITS, dsv_pkg::SUB_MAX, 32'h7fff_ffff);
    chk("min", min_sp, 32'd100);
    chk("max", max_sp, 32'h7fff_ffff);
    obj(1'b1, dsv_pkg::IDX_LIMITS, dsv_pkg::SUB_MIN, 32'h8000_0005);
    chk("neg_limit_refused", st[2], 1'b1);
    chk("min_kept", min_sp, 32'd100);
    obj(1'b0, dsv_pkg::IDX_LIMITS, 8'h03, 32'h0);
    chk("bad_sub_err", st[1], 1'b1);
    obj(1'b1, dsv_pkg::IDX_MODE_SEL, 8'h00, 32'h5);
    chk("mode_refused", st[2], 1'b1);
    rdchk("mode_kept", dsv_pkg::IDX_MODE_SEL, 8'h00, 32'h2);
    chk("active_mode", act_mode, dsv_pkg::MODE_VELOCITY);
    obj(1'b1, dsv_pkg::IDX_MODE_SEL, 8'h00, 32'h2);
    chk("mode_ok", st[2:1], 2'b00);
    obj(1'b1, dsv_pkg::IDX_STATUS, 8'h00, 32'h1);
    chk("status_wr_refused", st[2], 1'b1);
    obj(1'b1, dsv_pkg::IDX_RAMPED, 8'h00, 32'h1);
    chk("ramped_wr_err", st[1], 1'b1);
    $display("test refusals done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
